// ===== verilog/cssc_channel.sv
// one serial channel in clock synchronous mode
// Summary of operation
// - eight data bits per word
// - internal clock is source over 2(n+1)
// - external clock taken from transfer clock pin
// - flow control: cts, rts or none
// - send needs enable and full buffer
// - cts low required before sending when cts flow control is selected
// - receive needs rx, tx enable, word
// - tx irq select 0: on buffer move
// - tx irq select 1: after shift done
// - rx irq when word reaches buffer
// - overrun seven clocks into next word
// - divider n is eight bits
// - overrun still stores word, no rx irq
// - data out idles high or floats
module cssc_channel
	import cssc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// prescaled serial sources, one-cycle enables
	input wire logic undivided_serial_source,
	input wire logic half_rate_serial_source,
	input wire logic eighth_rate_serial_source,
	input wire logic thirtysecond_rate_serial_source,
	// serial pins
	input wire logic transfer_clock_pin_in,
	output logic transfer_clock_pin_out,
	output logic transfer_clock_pin_oe,
	output logic serial_data_out_pin,
	output logic serial_data_out_pin_oe,
	input wire logic serial_data_in_pin,
	input wire logic cts_n_pin,
	output logic rts_n_pin,
	// interrupt
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FIRST = 2'b01,
		ST_SHIFT = 2'b10
	} cssc_state_type;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end else begin
			sync1_q <= {cts_n_pin, serial_data_in_pin, transfer_clock_pin_in};
			sync2_q <= sync1_q;
		end
	end
	logic ext_clk, rxd, cts_n;
	assign ext_clk = sync2_q[0];
	assign rxd = sync2_q[1];
	assign cts_n = sync2_q[2];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] mode_q, brg_q, txbuf_q, rxbuf_q, rxsh_q, txsh_q;
	logic tx_en_q, rx_en_q, tx_empty_q, rx_full_q, tx_irq_sel_q, ovr_q;
	logic [2:0] stat_q, mask_q;
	cssc_state_type state_q;
	logic [3:0] bit_q;
	logic load, word_done, ovr_hit;
	logic [2:0] ev;
	logic wr_tx;
	assign wr_tx = reg_wr && reg_addr == ADDR_TXBUF;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_RESET;
			brg_q <= BRG_RESET;
			tx_en_q <= 1'b0;
			rx_en_q <= 1'b0;
			tx_irq_sel_q <= 1'b0;
			mask_q <= 3'h0;
			txbuf_q <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_BRG) brg_q <= reg_wdata;
			if (reg_addr == ADDR_MODE) mode_q <= reg_wdata;
			if (reg_addr == ADDR_TXBUF) txbuf_q <= reg_wdata;
			if (reg_addr == ADDR_IRQ_MASK) mask_q <= reg_wdata[2:0];
			if (reg_addr == ADDR_CTRL) begin
				tx_en_q <= reg_wdata[CTRL_TX_EN];
				rx_en_q <= reg_wdata[CTRL_RX_EN];
				tx_irq_sel_q <= reg_wdata[CTRL_TX_IRQ_SEL];
			end
		end
	end

	// ----------------------------------------
	// transfer clock
	// ----------------------------------------
	logic src_tick, int_clk_q, ext_clk_q, lead, trail;
	logic [7:0] div_q;
	always_comb begin
		unique case (mode_q[MODE_SRC_LSB +: 2])
			2'b00: src_tick = undivided_serial_source;
			2'b01: src_tick = half_rate_serial_source;
			2'b10: src_tick = eighth_rate_serial_source;
			2'b11: src_tick = thirtysecond_rate_serial_source;
		endcase
	end
	logic int_tick;
	assign int_tick = src_tick && div_q == 8'h00;
	// limitation: half period under five cycles outruns the input synchroniser
	// half period is n+1 source ticks; clock only runs while shifting
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_q <= 8'h00;
			int_clk_q <= 1'b1;
		end else if (state_q == ST_IDLE) begin
			div_q <= brg_q;
			int_clk_q <= 1'b1;
		end else if (src_tick) begin
			div_q <= (div_q == 8'h00) ? brg_q : div_q - 8'h01;
			if (div_q == 8'h00) int_clk_q <= ~int_clk_q;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) ext_clk_q <= 1'b1;
		else ext_clk_q <= ext_clk;
	end
	// leading edge shifts out, trailing edge samples; pol flips both
	logic pol_idle;
	assign pol_idle = ~mode_q[MODE_POL];
	always_comb begin
		if (mode_q[MODE_CKDIR]) begin
			lead = ext_clk != ext_clk_q && ext_clk_q == pol_idle;
			trail = ext_clk != ext_clk_q && ext_clk_q != pol_idle;
		end else begin
			lead = int_tick && int_clk_q;
			trail = int_tick && !int_clk_q;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			transfer_clock_pin_out <= 1'b1;
			transfer_clock_pin_oe <= 1'b0;
		end else begin
			transfer_clock_pin_out <= int_clk_q ~^ pol_idle;
			transfer_clock_pin_oe <= ~mode_q[MODE_CKDIR];
		end
	end

	// ----------------------------------------
	// shifter
	// ----------------------------------------
	logic start_ok;
	// start only with word waiting and cts low if selected
	// external clock must sit at idle level
	assign start_ok = tx_en_q && !tx_empty_q
		&& !(mode_q[MODE_FLOW_EN] && mode_q[MODE_CTS_SEL] && cts_n)
		&& !(mode_q[MODE_CKDIR] && ext_clk != pol_idle);
	assign load = state_q == ST_IDLE && start_ok;
	// receive rides on a transmit start
	logic rx_active_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			txsh_q <= 8'h00;
			rxsh_q <= 8'h00;
			rx_active_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: if (load) begin
					state_q <= ST_FIRST;
					txsh_q <= txbuf_q;
					bit_q <= 4'h0;
					rx_active_q <= rx_en_q;
				end
				ST_FIRST: if (lead) state_q <= ST_SHIFT;
				ST_SHIFT: if (trail) begin
					rxsh_q <= {rxd, rxsh_q[7:1]};
					bit_q <= bit_q + 4'h1;
					if (bit_q == WORD_BITS - 4'h1) state_q <= ST_IDLE;
				end else if (lead) txsh_q <= {1'b1, txsh_q[7:1]};
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	assign word_done = state_q == ST_SHIFT && trail && bit_q == WORD_BITS - 4'h1;
	// seventh sampling edge of next word while buffer unread
	assign ovr_hit = state_q == ST_SHIFT && trail && rx_active_q && rx_full_q
		&& bit_q == OVR_PERIODS - 4'h1;

	// ----------------------------------------
	// flags and buffers
	// ----------------------------------------
	logic rd_rx;
	assign rd_rx = reg_rd && reg_addr == ADDR_RXBUF;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_empty_q <= 1'b1;
			rx_full_q <= 1'b0;
			ovr_q <= 1'b0;
			rxbuf_q <= 8'h00;
		end else begin
			// move sets empty, write clears; write wins
			if (wr_tx) tx_empty_q <= 1'b0;
			else if (load) tx_empty_q <= 1'b1;
			if (word_done && rx_active_q) begin
				rxbuf_q <= {rxd, rxsh_q[7:1]};
				rx_full_q <= 1'b1;
			end else if (rd_rx) rx_full_q <= 1'b0;
			if (ovr_hit) ovr_q <= 1'b1;
			else if (rd_rx) ovr_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_comb begin
		ev = 3'h0;
		ev[IRQ_TX] = tx_irq_sel_q ? word_done : load;
		// no receive event on overrun word
		ev[IRQ_RX] = word_done && rx_active_q && !ovr_q && !ovr_hit;
		ev[IRQ_OVR] = ovr_hit;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) stat_q <= 3'h0;
		else if (reg_wr && reg_addr == ADDR_IRQ_STAT) stat_q <= (stat_q & ~reg_wdata[2:0]) | ev;
		else stat_q <= stat_q | ev;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) irq <= 1'b0;
		else irq <= |(stat_q & mask_q);
	end

	// ----------------------------------------
	// pins and read port
	// ----------------------------------------
	// last bit held past its sampling edge
	// pin clock edge and idle level would otherwise move together
	logic tail_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) tail_q <= 1'b0;
		else tail_q <= word_done;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_data_out_pin <= 1'b1;
			serial_data_out_pin_oe <= 1'b0;
			rts_n_pin <= 1'b1;
		end else begin
			// idle high; open drain floats a one
			serial_data_out_pin <= (state_q == ST_SHIFT || tail_q) ? txsh_q[0] : 1'b1;
			serial_data_out_pin_oe <= ~mode_q[MODE_OPEN_DRAIN]
				|| ((state_q == ST_SHIFT || tail_q) && !txsh_q[0]);
			// rts low while ready to receive
			rts_n_pin <= ~(mode_q[MODE_FLOW_EN] && !mode_q[MODE_CTS_SEL]
				&& rx_en_q && !rx_full_q);
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) reg_rdata <= 8'h00;
		else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_TXBUF: reg_rdata <= txbuf_q;
				ADDR_RXBUF: reg_rdata <= rxbuf_q;
				ADDR_BRG: reg_rdata <= brg_q;
				ADDR_MODE: reg_rdata <= mode_q;
				ADDR_CTRL: reg_rdata <= {1'b0, ovr_q, state_q == ST_IDLE, tx_irq_sel_q,
					rx_full_q, rx_en_q, tx_empty_q, tx_en_q};
				ADDR_IRQ_STAT: reg_rdata <= {5'h00, stat_q};
				ADDR_IRQ_MASK: reg_rdata <= {5'h00, mask_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else reg_rdata <= 8'h00;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_word_eight_bits: assert property (@(posedge sys_clk) disable iff (rst)
		word_done |=> state_q == ST_IDLE && bit_q == WORD_BITS)
		else $error("word ended on wrong bit");
	a_start_needs_word: assert property (@(posedge sys_clk) disable iff (rst)
		load |-> tx_en_q && !tx_empty_q) else $error("start without word");
	a_cts_gate: assert property (@(posedge sys_clk) disable iff (rst)
		load && mode_q[MODE_FLOW_EN] && mode_q[MODE_CTS_SEL] |-> !cts_n)
		else $error("start while cts high");
	a_empty_on_move: assert property (@(posedge sys_clk) disable iff (rst)
		load && !wr_tx |=> tx_empty_q) else $error("empty flag not set");
	a_tx_irq_early: assert property (@(posedge sys_clk) disable iff (rst)
		load && !tx_irq_sel_q |=> stat_q[IRQ_TX]) else $error("tx irq missing");
	a_tx_irq_late: assert property (@(posedge sys_clk) disable iff (rst)
		word_done && tx_irq_sel_q |=> stat_q[IRQ_TX]) else $error("tx irq missing");
	a_rx_store: assert property (@(posedge sys_clk) disable iff (rst)
		word_done && rx_active_q |=> rx_full_q && (rxbuf_q == (($past(rxsh_q) >> 1) |
		{$past(rxd), 7'h00}))) else $error("word not stored");
	a_idle_high: assert property (@(posedge sys_clk) disable iff (rst)
		$past(state_q) != ST_SHIFT && !$past(tail_q) |-> serial_data_out_pin)
		else $error("data out not idle");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
		##1 irq == |($past(stat_q) & $past(mask_q))) else $error("irq mismatch");
endmodule

// ===== verilog/cssc_pkg.sv
// constants for the clock synchronous serial channel
package cssc_pkg;
	// register offsets (word index == byte address / 4 not used; plain port)
	localparam logic [3:0] ADDR_TXBUF = 4'h0;
	localparam logic [3:0] ADDR_RXBUF = 4'h1;
	localparam logic [3:0] ADDR_BRG = 4'h2;
	localparam logic [3:0] ADDR_MODE = 4'h3;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
	// mode register fields
	localparam int MODE_SRC_LSB = 0;
	localparam int MODE_CKDIR = 3;
	localparam int MODE_CTS_SEL = 4;
	localparam int MODE_FLOW_EN = 5;
	localparam int MODE_POL = 6;
	localparam int MODE_OPEN_DRAIN = 7;
	// control register fields
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_TX_EMPTY = 1;
	localparam int CTRL_RX_EN = 2;
	localparam int CTRL_RX_FULL = 3;
	localparam int CTRL_TX_IRQ_SEL = 4;
	localparam int CTRL_SHIFT_EMPTY = 5;
	localparam int CTRL_OVERRUN = 6;
	// interrupt status bits
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_OVR = 2;
	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BRG_RESET = 8'h00;
	// word length and overrun point
	localparam logic [3:0] WORD_BITS = 4'h8;
	localparam logic [3:0] OVR_PERIODS = 4'h7;
endpackage

// ===== test/cssc_partner.sv
// far-side model: synchronous serial device on the transfer clock
module cssc_partner (
	// clock, reset, frame start
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic arm,
	// frame setup and wires
	input wire logic pol,
	input wire logic [7:0] tx_word,
	input wire logic clk_wire,
	input wire logic dev_data,
	// outputs
	output logic part_data,
	output logic [7:0] rx_word,
	output logic [3:0] nbits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev_q;
	logic [3:0] lead_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b1;
			lead_q <= 4'h8;
			nbits <= 4'h8;
			part_data <= 1'b0;
		end else begin
			prev_q <= clk_wire;
			if (arm) begin
				lead_q <= 4'h0;
				nbits <= 4'h0;
				// own bit moves on the leading edge, lsb first
			end else if (prev_q != pol && clk_wire == pol && lead_q < 4'h8) begin
				part_data <= tx_word[lead_q[2:0]];
				lead_q <= lead_q + 4'h1;
				// device bit taken on the trailing edge
			end else if (prev_q == pol && clk_wire != pol && nbits < 4'h8) begin
				rx_word[nbits[2:0]] <= dev_data;
				nbits <= nbits + 4'h1;
			end else if (nbits == 4'h8) begin
				// released line toggles so a stale bit never reads as valid
				part_data <= ~part_data;
			end
		end
	end
endmodule

// ===== test/testbench.sv
// self-checking bench: channel against the far-side model
module testbench import cssc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, arm = 1'b0;
	logic cts_n = 1'b0, ext_clk = 1'b1, pol = 1'b0, wire_q = 1'b1, src_h = 1'b0;
	logic src_e = 1'b0, src_t = 1'b0, clk_o, clk_oe, dout, dout_oe, pdata, rts_n, irq;
	logic [3:0] reg_addr = 4'h0, nbits;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rdv, pw = 8'h00, rxw, cnt = 8'h00, w, n;
	logic [15:0] run_len = 16'h0000, half_seen = 16'h0000;
	int err_total = 0, checks = 0, cyc = 0;
	int per [4] = '{1, 2, 8, 32};
	wire logic clk_wire = clk_oe ? clk_o : ext_clk;
	wire logic dev_data = dout_oe ? dout : 1'b1;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cnt <= cnt + 8'h01;
		src_h <= cnt[0];
		src_e <= (cnt[2:0] == 3'h7);
		src_t <= (cnt[4:0] == 5'h1f);
		wire_q <= clk_wire;
		run_len <= (clk_wire != wire_q) ? 16'h0001 : run_len + 16'h0001;
		if (clk_wire != wire_q) begin
			half_seen <= run_len;
		end
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end
	cssc_channel u_cssc_channel (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.undivided_serial_source(1'b1), .half_rate_serial_source(src_h),
		.eighth_rate_serial_source(src_e), .thirtysecond_rate_serial_source(src_t),
		.transfer_clock_pin_in(clk_wire), .transfer_clock_pin_out(clk_o),
		.transfer_clock_pin_oe(clk_oe), .serial_data_out_pin(dout), .irq(irq),
		.serial_data_out_pin_oe(dout_oe), .serial_data_in_pin(pdata), .cts_n_pin(cts_n),
		.rts_n_pin(rts_n));
	cssc_partner u_cssc_partner (.sys_clk(sys_clk), .rst(rst), .arm(arm), .pol(pol),
		.tx_word(pw), .clk_wire(clk_wire), .dev_data(dev_data), .part_data(pdata),
		.rx_word(rxw), .nbits(nbits));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic we, input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= we;
		reg_rd <= !we;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask
	task automatic go(input logic sel, input logic moved);
		w = 8'($urandom);
		@(posedge sys_clk);
		pw <= 8'($urandom);
		arm <= 1'b1;
		@(posedge sys_clk);
		arm <= 1'b0;
		acc(1'b1, ADDR_TXBUF, w);
		acc(1'b1, ADDR_CTRL, {3'h0, sel, 4'h5});
		repeat (4) @(posedge sys_clk);
		acc(1'b0, ADDR_IRQ_STAT, 8'h00);
		chk("tx_irq_early", 16'(rdv[IRQ_TX]), 16'(moved & !sel));
		acc(1'b0, ADDR_CTRL, 8'h00);
		chk("tx_empty", 16'(rdv[CTRL_TX_EMPTY]), 16'(moved));
	endtask
	task automatic done(input logic ext, input logic [7:0] stat, input logic irq_exp);
		// outside clock runs only within the frame, from idle level
		repeat (ext ? 16 : 0) begin
			repeat (8) @(posedge sys_clk);
			ext_clk <= ~ext_clk;
		end
		for (int i = 0; i < 6000 && nbits != 4'h8; i++)
			@(posedge sys_clk);
		repeat (12) @(posedge sys_clk);
		#1 chk("partner_rx", 16'(rxw), 16'(w));
		chk("frame_end", 16'(nbits), 16'h0008);
		chk("irq_level", 16'(irq), 16'(irq_exp));
		acc(1'b0, ADDR_IRQ_STAT, 8'h00);
		chk("irq_status", 16'(rdv), 16'(stat));
		acc(1'b1, ADDR_IRQ_STAT, 8'h07);
		acc(1'b1, ADDR_CTRL, 8'h00);
	endtask
	task automatic close_out();
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// half period in clock cycles: (n+1) source ticks
	function automatic logic [15:0] half_exp(input logic [7:0] nv, input int src);
		return 16'((int'(nv) + 1) * per[src]);
	endfunction
	initial begin
		void'($urandom(32'hbf5a));
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk("data_idle", 16'(dout), 16'h0001);
		acc(1'b0, 4'hf, 8'h00);
		chk("unmapped", 16'(rdv), 16'h0000);
		acc(1'b1, ADDR_IRQ_MASK, 8'h07);
		for (int s = 0; s < 4; s++) begin
			// short halves would outrun the channel's input synchroniser
			n = (s == 0) ? 8'hff : 8'(2 + $urandom % 4);
			pol <= 1'($urandom);
			acc(1'b1, ADDR_BRG, n);
			acc(1'b1, ADDR_MODE, {1'b0, pol, 4'h0, 2'(s)});
			go(s[0], 1'b1);
			done(1'b0, 8'h03, 1'b1);
			chk("half_period", half_seen, half_exp(n, s));
			acc(1'b0, ADDR_RXBUF, 8'h00);
			chk("rx_word", 16'(rdv), 16'(pw));
		end
		acc(1'b1, ADDR_MODE, 8'h30);
		cts_n <= 1'b1;
		go(1'b1, 1'b0);
		repeat (200) @(posedge sys_clk);
		#1 chk("cts_hold", 16'(nbits), 16'h0000);
		@(posedge sys_clk);
		cts_n <= 1'b0;
		done(1'b0, 8'h03, 1'b1);
		acc(1'b0, ADDR_RXBUF, 8'h00);
		acc(1'b1, ADDR_MODE, 8'h20);
		acc(1'b1, ADDR_CTRL, 8'h04);
		repeat (3) @(posedge sys_clk);
		#1 chk("rts_low", 16'(rts_n), 16'h0000);
		acc(1'b1, ADDR_MODE, 8'h00);
		acc(1'b1, ADDR_BRG, 8'h05);
		go(1'b0, 1'b1);
		done(1'b0, 8'h03, 1'b1);
		go(1'b0, 1'b1);
		done(1'b0, 8'h05, 1'b1);
		acc(1'b0, ADDR_CTRL, 8'h00);
		chk("overrun", 16'(rdv[CTRL_OVERRUN]), 16'h0001);
		acc(1'b0, ADDR_RXBUF, 8'h00);
		chk("rx_overwrite", 16'(rdv), 16'(pw));
		w = 8'($urandom);
		pol <= w[0];
		ext_clk <= ~w[0];
		acc(1'b1, ADDR_IRQ_MASK, 8'h04);
		acc(1'b1, ADDR_MODE, {1'b0, pol, 6'h08});
		go(1'b0, 1'b1);
		done(1'b1, 8'h03, 1'b0);
		acc(1'b0, ADDR_RXBUF, 8'h00);
		chk("ext_rx_word", 16'(rdv), 16'(pw));
		acc(1'b1, ADDR_MODE, 8'h80);
		repeat (3) @(posedge sys_clk);
		#1 chk("od_float", 16'(dout_oe), 16'h0000);
		close_out();
	end
endmodule
